// ===== design/mpc_pkg.sv
`default_nettype none
package mpc_pkg;
    localparam int DATA_W = 20;
    localparam int HALF_W = 10;
    localparam int ADDR_W = 4;
    localparam int REG_W = 8;
    localparam int SYNC_BIT = 19;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h2;

    localparam int CTRL_LINK_EN = 0;
    localparam int CTRL_OPT_MODE = 1;
    localparam int CTRL_SEC_INV = 2;
    localparam logic [REG_W-1:0] CTRL_MASK = 8'h07;
    localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

    localparam int FLAG_CS_HIGH = 0;
    localparam int FLAG_BAD_CFG = 1;
    localparam int FLAG_TX_OVF = 2;
    localparam int FLAG_RX_UNF = 3;
    localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;

    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_INTERP_LSB = 4;
    localparam int STAT_DONE_BIT = 6;
    localparam int STAT_RUN_BIT = 7;

    localparam logic [3:0] MODE_NUM_NONE = 4'h0;
    localparam logic [3:0] MODE_NUM_FD = 4'h1;
    localparam logic [3:0] MODE_NUM_FD_OPT = 4'h2;
    localparam logic [3:0] MODE_NUM_HALF_DUPLEX_WIDE_MODE = 4'h4;
    localparam logic [3:0] MODE_NUM_HALF_DUPLEX_NARROW_MODE = 4'h7;
    localparam logic [3:0] MODE_NUM_HALF_DUPLEX_NARROW_MODE_OPT = 4'h8;

    localparam logic [1:0] INTERP_1X = 2'h0;
    localparam logic [1:0] INTERP_2X = 2'h1;
    localparam logic [1:0] INTERP_4X = 2'h2;
    localparam logic [1:0] INTERP_RSVD = 2'h3;

    localparam logic [1:0] PLL_BYPASS = 2'h0;
    localparam logic [1:0] PLL_2X = 2'h1;
    localparam logic [1:0] PLL_4X = 2'h2;

    // two synchroniser stages plus one spare cycle before the straps are trusted
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

    typedef enum logic [1:0] {
        MPC_FULL_DUPLEX,
        MPC_HALF_WIDE,
        MPC_HALF_NARROW
    } mpc_duplex_e;

    typedef struct packed {
        mpc_duplex_e duplex;
        logic [1:0] interp;
        logic [1:0] pll;
        logic bad;
    } mpc_cfg_s;

    typedef struct packed {
        logic ref_clk;
        logic dir;
        logic cs;
        logic duplex;
        logic width;
        logic interp_hi;
        logic interp_lo;
        logic [DATA_W-1:0] data;
    } mpc_pins_s;
endpackage : mpc_pkg
`default_nettype wire

// ===== design/mpc_sync.sv
`default_nettype none
module mpc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : mpc_sync
`default_nettype wire

// ===== design/mpc_buf2.sv
`default_nettype none
module mpc_buf2 #(
    parameter int W = 20
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    // head entry is the output register itself, so the drain side sees a flop
    logic [W-1:0] tail_q;
    logic tail_v_q;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire head_v_d = pop ? (tail_v_q | push) : (out_valid_o | push);
    wire tail_v_d = pop ? (tail_v_q & push) : (tail_v_q | (push & out_valid_o));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            tail_v_q <= 1'b0;
            in_ready_o <= 1'b0;
            out_data_o <= '0;
            tail_q <= '0;
        end else if (ce_i) begin
            out_valid_o <= head_v_d;
            tail_v_q <= tail_v_d;
            in_ready_o <= ~tail_v_d;
            if (pop) begin
                out_data_o <= tail_v_q ? tail_q : in_data_i;
            end else if (push & ~out_valid_o) begin
                out_data_o <= in_data_i;
            end
            if (push & (pop ? tail_v_q : out_valid_o)) begin
                tail_q <= in_data_i;
            end
        end
    end
endmodule : mpc_buf2
`default_nettype wire

// ===== design/mpc_top.sv
// The address map and the strobed register port are this design's own decisions.
`default_nettype none
module mpc_top (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic REF_CLOCK_IN_I,
    input wire logic SERIAL_CS_I,
    input wire logic DUPLEX_SELECT_STRAP_I,
    input wire logic INTERP_STRAP_HI_I,
    input wire logic INTERP_STRAP_LO_I,
    input wire logic IFACE_DIR_PIN_I,
    input wire logic SECONDARY_IFACE_CLOCK_I,
    output logic SECONDARY_IFACE_CLOCK_O,
    output logic SECONDARY_IFACE_CLOCK_OE_N_O,
    output logic PRIMARY_IFACE_CLOCK_O,
    input wire logic [mpc_pkg::DATA_W-1:0] DATA_I,
    output logic [mpc_pkg::DATA_W-1:0] DATA_O,
    output logic [mpc_pkg::DATA_W-1:0] DATA_OE_N_O,
    output logic [mpc_pkg::DATA_W-1:0] TX_WORD_O,
    output logic TX_VALID_O,
    input wire logic TX_READY_I,
    input wire logic [mpc_pkg::DATA_W-1:0] RX_WORD_I,
    input wire logic RX_VALID_I,
    output logic RX_READY_O,
    input wire logic [mpc_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [mpc_pkg::REG_W-1:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    output logic [mpc_pkg::REG_W-1:0] REG_RDATA_O
);
    import mpc_pkg::*;

    typedef enum {
        ST_STRAP_WAIT,
        ST_IDLE,
        ST_RUN
    } mpc_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic mpc_cfg_s decode_straps(input logic duplex, input logic width,
                                               input logic hi, input logic lo);
        mpc_cfg_s c;
        c.duplex = duplex ? MPC_FULL_DUPLEX : (width ? MPC_HALF_NARROW : MPC_HALF_WIDE);
        c.interp = {hi, lo};
        c.bad = 1'b0;
        if (c.interp == INTERP_RSVD) begin
            c.interp = INTERP_2X;
            c.bad = 1'b1;
        end
        // interleaved words cannot be fed at 1x, so fall back to 2x and flag it
        if (c.interp == INTERP_1X && c.duplex != MPC_HALF_WIDE) begin
            c.interp = INTERP_2X;
            c.bad = 1'b1;
        end
        c.pll = (c.interp == INTERP_1X) ? PLL_BYPASS :
                ((c.interp == INTERP_2X) ? PLL_2X : PLL_4X);
        return c;
    endfunction : decode_straps

    function automatic logic [3:0] mode_number(input mpc_duplex_e d, input logic opt);
        logic [3:0] m;
        case (d)
            MPC_FULL_DUPLEX: m = opt ? MODE_NUM_FD_OPT : MODE_NUM_FD;
            MPC_HALF_NARROW: m = opt ? MODE_NUM_HALF_DUPLEX_NARROW_MODE_OPT : MODE_NUM_HALF_DUPLEX_NARROW_MODE;
            default: m = MODE_NUM_HALF_DUPLEX_WIDE_MODE;
        endcase
        return m;
    endfunction : mode_number

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    mpc_pins_s pins_raw;
    mpc_pins_s pins_s;

    assign pins_raw = '{ref_clk: REF_CLOCK_IN_I, dir: IFACE_DIR_PIN_I, cs: SERIAL_CS_I,
                        duplex: DUPLEX_SELECT_STRAP_I, width: SECONDARY_IFACE_CLOCK_I,
                        interp_hi: INTERP_STRAP_HI_I, interp_lo: INTERP_STRAP_LO_I,
                        data: DATA_I};

    mpc_sync #(.W($bits(mpc_pins_s))) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // configuration and state

    mpc_state_e st_q, st_d;
    logic [1:0] settle_q;
    mpc_cfg_s cfg_q;
    logic [REG_W-1:0] ctrl_q, flags_q;

    wire settle_done = (settle_q == STRAP_SETTLE_CYC);
    wire strap_latch = (st_q == ST_STRAP_WAIT) & settle_done;
    wire cfg_done = (st_q != ST_STRAP_WAIT);
    wire link_on = (st_q == ST_RUN);
    wire opt_mode = ctrl_q[CTRL_OPT_MODE];
    wire is_fd = (cfg_q.duplex == MPC_FULL_DUPLEX);
    wire is_half_duplex_wide_mode = (cfg_q.duplex == MPC_HALF_WIDE);
    wire is_half_duplex_narrow_mode = (cfg_q.duplex == MPC_HALF_NARROW);
    wire mode2 = is_fd & opt_mode;
    wire mode8 = is_half_duplex_narrow_mode & opt_mode;
    wire [3:0] mode_num = cfg_done ? mode_number(cfg_q.duplex, opt_mode) : MODE_NUM_NONE;
    wire mpc_cfg_s strap_cfg = decode_straps(pins_s.duplex, pins_s.width,
                                             pins_s.interp_hi, pins_s.interp_lo);

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_STRAP_WAIT: st_d = settle_done ? ST_IDLE : ST_STRAP_WAIT;
            ST_IDLE: st_d = ctrl_q[CTRL_LINK_EN] ? ST_RUN : ST_IDLE;
            ST_RUN: st_d = ctrl_q[CTRL_LINK_EN] ? ST_RUN : ST_IDLE;
            default: st_d = ST_STRAP_WAIT;
        endcase
    end

    // the straps are looked at once; later pin changes are ignored until reset
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            st_q <= ST_STRAP_WAIT;
            settle_q <= '0;
            cfg_q <= '0;
        end else if (CE_I) begin
            st_q <= st_d;
            if (!settle_done) begin
                settle_q <= settle_q + 2'h1;
            end
            if (strap_latch) begin
                cfg_q <= strap_cfg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interface clocks

    logic ref_d_q, pri_clk_q, rise_q;
    wire ref_tick = pins_s.ref_clk & ~ref_d_q;
    wire pri_rise = link_on & ref_tick & ~pri_clk_q;
    wire pri_fall = link_on & ref_tick & pri_clk_q;
    wire pri_clk_d = link_on & (pri_clk_q ^ ref_tick);
    wire tx_dir = is_fd | pins_s.dir;
    wire rx_dir = is_fd | ~pins_s.dir;
    wire launch = rise_q & link_on & rx_dir;
    wire tx_cap = pri_fall & tx_dir;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ref_d_q <= 1'b0;
            pri_clk_q <= 1'b0;
            rise_q <= 1'b0;
        end else if (CE_I) begin
            ref_d_q <= pins_s.ref_clk;
            pri_clk_q <= pri_clk_d;
            rise_q <= pri_rise;
        end
    end

    assign PRIMARY_IFACE_CLOCK_O = pri_clk_q;

    ////////////////////////////////////////////////////////////////////////////////
    // transmit capture

    logic tx_phase_q;
    logic [HALF_W-1:0] tx_lo_q;
    logic tx_in_ready;
    wire [HALF_W-1:0] tx_half = pins_s.data[HALF_W-1:0];
    wire tx_push = tx_cap & (is_half_duplex_wide_mode | tx_phase_q);
    wire [DATA_W-1:0] tx_word = is_half_duplex_wide_mode ? pins_s.data : {tx_half, tx_lo_q};
    wire tx_ovf = tx_push & ~tx_in_ready;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            tx_phase_q <= 1'b0;
            tx_lo_q <= '0;
        end else if (CE_I) begin
            if (!link_on) begin
                tx_phase_q <= 1'b0;
            end else if (tx_cap & ~is_half_duplex_wide_mode) begin
                tx_phase_q <= ~tx_phase_q;
                tx_lo_q <= tx_phase_q ? tx_lo_q : tx_half;
            end
        end
    end

    mpc_buf2 #(.W(DATA_W)) u_tx_buf (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .in_valid_i(tx_push),
        .in_data_i(tx_word),
        .in_ready_o(tx_in_ready),
        .out_valid_o(TX_VALID_O),
        .out_data_o(TX_WORD_O),
        .out_ready_i(TX_READY_I)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // receive launch

    logic rx_valid, rx_phase_q, sync2_q;
    logic [DATA_W-1:0] rx_word;
    wire rx_pop = launch & rx_valid & (is_half_duplex_wide_mode | rx_phase_q);
    wire rx_unf = launch & ~rx_valid;
    wire rx_first = launch & rx_valid & ~rx_phase_q & ~is_half_duplex_wide_mode;
    wire [HALF_W-1:0] rx_half = rx_phase_q ? rx_word[DATA_W-1:HALF_W] : rx_word[HALF_W-1:0];
    wire [HALF_W-1:0] zero_half = '0;
    wire [HALF_W-2:0] zero_gap = '0;
    wire [DATA_W-1:0] all_off = '1;
    wire [DATA_W-1:0] rx_bits = ~rx_valid ? '0 :
                                (is_half_duplex_wide_mode ? rx_word :
                                (is_fd ? {rx_half, zero_half} :
                                {mode8 & ~rx_phase_q, zero_gap, rx_half}));
    wire [DATA_W-1:0] oe_n_d = ~link_on ? all_off :
                               (is_fd ? {zero_half, ~zero_half} :
                               (~rx_dir ? all_off :
                               (is_half_duplex_wide_mode ? ~all_off : {~mode8, ~zero_gap, zero_half})));
    wire sync2_d = launch ? rx_first : sync2_q;
    wire sec_oe_n_d = ~(link_on & is_fd);
    wire sec_o_d = mode2 ? sync2_d : (pri_clk_d ^ ctrl_q[CTRL_SEC_INV]);

    mpc_buf2 #(.W(DATA_W)) u_rx_buf (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .in_valid_i(RX_VALID_I),
        .in_data_i(RX_WORD_I),
        .in_ready_o(RX_READY_O),
        .out_valid_o(rx_valid),
        .out_data_o(rx_word),
        .out_ready_i(rx_pop)
    );

    // data move only one cycle after the clock rises, leaving the far end a clean edge
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            rx_phase_q <= 1'b0;
            sync2_q <= 1'b0;
            DATA_O <= '0;
            DATA_OE_N_O <= '1;
            SECONDARY_IFACE_CLOCK_O <= 1'b0;
            SECONDARY_IFACE_CLOCK_OE_N_O <= 1'b1;
        end else if (CE_I) begin
            if (!link_on) begin
                rx_phase_q <= 1'b0;
            end else if (launch & rx_valid & ~is_half_duplex_wide_mode) begin
                rx_phase_q <= ~rx_phase_q;
            end
            if (launch) begin
                DATA_O <= rx_bits;
            end
            sync2_q <= sync2_d;
            DATA_OE_N_O <= oe_n_d;
            SECONDARY_IFACE_CLOCK_O <= sec_o_d;
            SECONDARY_IFACE_CLOCK_OE_N_O <= sec_oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register port

    wire wr_ctrl = REG_WE_I & (REG_ADDR_I == ADDR_CTRL);
    wire wr_flags = REG_WE_I & (REG_ADDR_I == ADDR_FLAGS);
    wire [REG_W-1:0] status = {link_on, cfg_done, cfg_q.interp, mode_num};
    wire [REG_W-1:0] flag_set = {4'h0, rx_unf, tx_ovf, strap_latch & strap_cfg.bad,
                                 cfg_done & pins_s.cs};
    // a new event beats a write-one-to-clear in the same cycle
    wire [REG_W-1:0] flags_d = (flags_q & ~(wr_flags ? REG_WDATA_I : '0)) | flag_set;
    wire [REG_W-1:0] rd_sel = (REG_ADDR_I == ADDR_CTRL) ? ctrl_q :
                              (REG_ADDR_I == ADDR_STATUS) ? status :
                              (REG_ADDR_I == ADDR_FLAGS) ? flags_q : '0;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ctrl_q <= CTRL_RESET;
            flags_q <= FLAGS_RESET;
            REG_RDATA_O <= '0;
        end else if (CE_I) begin
            if (wr_ctrl) begin
                ctrl_q <= REG_WDATA_I & CTRL_MASK;
            end
            flags_q <= flags_d;
            REG_RDATA_O <= REG_RE_I ? rd_sel : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_strap_held: assert property (cfg_done && $past(cfg_done) |-> $stable(cfg_q))
        else $error("strap configuration changed after latch");

    a_duplex_decode: assert property (strap_latch && CE_I |=>
        cfg_q.duplex == ($past(pins_s.duplex) ? MPC_FULL_DUPLEX :
                         ($past(pins_s.width) ? MPC_HALF_NARROW : MPC_HALF_WIDE)))
        else $error("duplex strap decoded wrongly");

    a_pll_follow: assert property (cfg_done |->
        (cfg_q.interp == INTERP_1X) == (cfg_q.pll == PLL_BYPASS) &&
        (cfg_q.interp == INTERP_4X) == (cfg_q.pll == PLL_4X))
        else $error("pll setting does not match interpolation");

    a_no_1x_interleave: assert property (cfg_done && !is_half_duplex_wide_mode |-> cfg_q.interp != INTERP_1X)
        else $error("interleaved mode running at 1x");

    a_sec_clk_fd: assert property (link_on && is_fd && !opt_mode && CE_I |=>
        !SECONDARY_IFACE_CLOCK_OE_N_O &&
        SECONDARY_IFACE_CLOCK_O == (PRIMARY_IFACE_CLOCK_O ^ ctrl_q[CTRL_SEC_INV]))
        else $error("secondary pin not a clock in full duplex");

    a_tx_on_fall: assert property (tx_cap && CE_I |-> PRIMARY_IFACE_CLOCK_O ##1
        !PRIMARY_IFACE_CLOCK_O)
        else $error("tx capture not on primary clock fall");

    a_rx_after_rise: assert property (launch && CE_I |->
        PRIMARY_IFACE_CLOCK_O && !$past(PRIMARY_IFACE_CLOCK_O))
        else $error("rx launch not right after primary rise");

    a_rx_data_out: assert property (launch && rx_valid && is_half_duplex_wide_mode && CE_I |=>
        DATA_O == $past(rx_word) && DATA_OE_N_O == '0)
        else $error("rx word not driven after launch");

    a_sync_mode2: assert property (rx_first && mode2 && CE_I |=>
        SECONDARY_IFACE_CLOCK_O ##1 !launch [*2])
        else $error("mode 2 sync marker missing");

    a_sync_mode8: assert property (rx_first && mode8 && CE_I |=> DATA_O[SYNC_BIT] &&
        !DATA_OE_N_O[SYNC_BIT])
        else $error("mode 8 sync marker missing");

    a_cs_flag: assert property (cfg_done && pins_s.cs && CE_I |=> flags_q[FLAG_CS_HIGH])
        else $error("serial select high not flagged");

    c_fd_run: cover property (link_on && is_fd && tx_push);
    c_mode8_sync: cover property (rx_first && mode8);
    c_half_duplex_wide_mode_rx: cover property (launch && rx_valid && is_half_duplex_wide_mode);
    c_tx_stall: cover property (tx_ovf);
endmodule : mpc_top
`default_nettype wire

// ===== bench/mpc_far_end.sv
`default_nettype none
module mpc_far_end (
    input wire logic clk_i,
    input wire logic pclk_i,
    input wire logic en_i,
    output logic [mpc_pkg::DATA_W-1:0] drv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import mpc_pkg::*;
    logic pclk_q = 1'b0;
    logic [DATA_W-1:0] val_q = '0;
    logic [DATA_W-1:0] nx;
    logic [DATA_W-1:0] sent[$];
    integer seed = 16;
    // a released bus must not look like the last word, so show its inverse
    assign drv_o = en_i ? val_q : ~val_q;
    always @(posedge clk_i) begin
        pclk_q <= pclk_i;
        // new word right after the rise keeps it steady around the fall
        if (en_i && pclk_i && !pclk_q) begin
            nx = DATA_W'($random(seed));
            val_q <= nx;
            sent.push_back(nx);
        end
    end
endmodule : mpc_far_end
`default_nettype wire

// ===== bench/mode_pin_config_and_iface_timing_tb_top.sv
`default_nettype none
module mode_pin_config_and_iface_timing_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mpc_pkg::*;
    logic clk = 0, rst_n = 0, ref_clk = 0, cs = 0, dup = 0, wid = 0, ih = 0, il = 0;
    logic dir = 0, tx_rdy = 0, rx_vld = 0, we = 0, re = 0, far_en = 0, ce = 1;
    logic [DATA_W-1:0] rx_word = '0;
    logic [ADDR_W-1:0] addr = '0;
    logic [REG_W-1:0] wdata = '0;
    wire logic [REG_W-1:0] rdata;
    wire logic [DATA_W-1:0] far_drv, dout, oe_n, bus, tx_word;
    wire logic sec_o, sec_oe_n, pclk, tx_vld, rx_rdy, sec_pin;
    integer seed = 16, err_count = 0, compares = 0, ph = 0;
    bit chk_tx = 0, chk_rx = 0, chk_mk = 0, mk_fd = 0, stall = 0;
    logic pclk_q = 0;
    logic [2:0] sr = '0;
    logic [8:0] e;
    logic [DATA_W-1:0] rxq[$];

    initial forever #10 clk = ~clk;
    initial begin
        #7;
        forever #80 ref_clk = ~ref_clk;
    end
    assign bus = (oe_n & far_drv) | (~oe_n & dout);
    assign sec_pin = sec_oe_n ? wid : sec_o;

    mpc_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REF_CLOCK_IN_I(ref_clk),
        .SERIAL_CS_I(cs), .DUPLEX_SELECT_STRAP_I(dup), .INTERP_STRAP_HI_I(ih),
        .INTERP_STRAP_LO_I(il), .IFACE_DIR_PIN_I(dir), .SECONDARY_IFACE_CLOCK_I(sec_pin),
        .SECONDARY_IFACE_CLOCK_O(sec_o), .SECONDARY_IFACE_CLOCK_OE_N_O(sec_oe_n),
        .PRIMARY_IFACE_CLOCK_O(pclk), .DATA_I(bus), .DATA_O(dout), .DATA_OE_N_O(oe_n),
        .TX_WORD_O(tx_word), .TX_VALID_O(tx_vld), .TX_READY_I(tx_rdy), .RX_WORD_I(rx_word),
        .RX_VALID_I(rx_vld), .RX_READY_O(rx_rdy), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata));
    mpc_far_end far (.clk_i(clk), .pclk_i(pclk), .en_i(far_en), .drv_o(far_drv));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_r(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_r
    task automatic chk_w(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_w
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        chk_r(rdata, exp);
    endtask : rd_chk
    // straps stay put across the whole reset so the latch sees settled values
    task automatic restart(input logic d, input logic w, input logic h, input logic l);
        @(posedge clk);
        {dup, wid, ih, il} <= {d, w, h, l};
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : restart
    function automatic logic [8:0] exp_cfg(input logic d, w, h, l);
        logic [3:0] m;
        logic [1:0] ip;
        logic bad;
        m = d ? MODE_NUM_FD : (w ? MODE_NUM_HALF_DUPLEX_NARROW_MODE : MODE_NUM_HALF_DUPLEX_WIDE_MODE);
        ip = {h, l};
        bad = (ip == INTERP_RSVD) || (ip == INTERP_1X && m != MODE_NUM_HALF_DUPLEX_WIDE_MODE);
        if (bad) ip = INTERP_2X;
        return {bad, 1'b0, 1'b1, ip, m};
    endfunction : exp_cfg
    task automatic conclude();
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        pclk_q <= pclk;
        sr <= {sr[1:0], pclk & ~pclk_q};
        tx_rdy <= !stall && (($random(seed) % 4) != 0);
        if (rx_vld && rx_rdy) begin
            rxq.push_back(rx_word);
            rx_word <= DATA_W'($random(seed));
        end
        if (chk_tx && tx_vld && tx_rdy) chk_w(tx_word, far.sent.pop_front());
        if (sr[2] && chk_rx) chk_w(dout, rxq.pop_front());
        if (sr[2] && chk_mk) begin
            chk_w({19'h0, mk_fd ? sec_o : dout[SYNC_BIT]}, {19'h0, ph[0] == 1'b0});
            ph++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk);
        chk_w(oe_n, '1);
        chk_w({19'h0, sec_oe_n}, 20'h1);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            e = exp_cfg(i[3], i[2], i[1], i[0]);
            restart(i[3], i[3] ? 1'($random(seed)) : i[2], i[1], i[0]);
            rd_chk(ADDR_STATUS, e[7:0]);
            rd_chk(ADDR_FLAGS, {6'h0, e[8], 1'b0});
        end
        {dup, ih, il} <= 3'h0;
        repeat (6) @(posedge clk);
        rd_chk(ADDR_STATUS, e[7:0]);
        cs <= 1'b1;
        repeat (6) @(posedge clk);
        cs <= 1'b0;
        rd_chk(ADDR_FLAGS, 8'h03);
        wr(ADDR_FLAGS, 8'h01);
        rd_chk(ADDR_FLAGS, 8'h02);
        rd_chk(4'hf, 8'h00);
        // transmit, host drives the bus
        dir <= 1'b1;
        restart(0, 0, 0, 1);
        far.sent.delete();
        far_en <= 1'b1;
        chk_tx = 1;
        wr(ADDR_CTRL, 8'h01);
        repeat (400) @(posedge clk);
        rd_chk(ADDR_STATUS, {2'b11, INTERP_2X, MODE_NUM_HALF_DUPLEX_WIDE_MODE});
        chk_tx = 0;
        far_en <= 1'b0;
        // receive, buffer kept full so every launch carries a word
        dir <= 1'b0;
        restart(0, 0, 0, 1);
        rxq.delete();
        rx_vld <= 1'b1;
        repeat (4) @(posedge clk);
        chk_rx = 1;
        wr(ADDR_CTRL, 8'h01);
        repeat (400) @(posedge clk);
        chk_rx = 0;
        chk_w(oe_n, '0);
        rx_vld <= 1'b0;
        // full duplex mode 1: inverted secondary clock, stalled tx, starved rx
        restart(1, 0, 0, 1);
        stall <= 1'b1;
        wr(ADDR_CTRL, 8'hfd);
        rd_chk(ADDR_CTRL, 8'h05);
        for (int j = 0; j < 4; j++) begin
            repeat (37) @(posedge clk);
            chk_w({19'h0, sec_o}, {19'h0, ~pclk});
        end
        // freeze just after a primary fall, well away from any launch
        for (int w = 0; w < 40 && !(pclk_q && !pclk); w++) @(posedge clk);
        if (!(pclk_q && !pclk)) err_count++;
        ce <= 1'b0;
        @(posedge clk);
        e[1:0] = {sec_o, pclk};
        repeat (20) @(posedge clk);
        chk_w({18'h0, sec_o, pclk}, {18'h0, e[1:0]});
        ce <= 1'b1;
        rd_chk(ADDR_STATUS, {2'b11, INTERP_2X, MODE_NUM_FD});
        rd_chk(ADDR_FLAGS, 8'h0c);
        stall <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            restart(k == 0, 1, 1, 0);
            mk_fd = (k == 0);
            ph = 0;
            rx_vld <= 1'b1;
            repeat (4) @(posedge clk);
            chk_mk = 1;
            wr(ADDR_CTRL, 8'h03);
            repeat (300) @(posedge clk);
            chk_mk = 0;
            rd_chk(ADDR_STATUS, {2'b11, INTERP_4X, mk_fd ? MODE_NUM_FD_OPT : MODE_NUM_HALF_DUPLEX_NARROW_MODE_OPT});
            if (mk_fd) chk_w({19'h0, sec_oe_n}, 20'h0);
            rx_vld <= 1'b0;
        end
        conclude();
    end
endmodule : mode_pin_config_and_iface_timing_tb_top
`default_nettype wire
